// File: rtl/rtcr_top.sv
// Clock and CMOS RAM block behind I/O ports 70h..77h.
// Assumes the host gives one-cycle rd/wr strobes in the clk_sys domain;
// the oscillator and the well reset arrive asynchronously from pins.
//
// Notes on behaviour
// - Alarm repeats from every second to monthly; periodic interrupt 125 to 500 ms.
// - An interrupt can flag that an update cycle has just finished.
// - Seconds through year are counted, leap years included.
// - Hours in 12 or 24 hour form; all fields BCD or binary.
// - The one-second tick divides the 32.768 kHz oscillator.
// - Bytes 0..9 hold time and date, 0Ah..0Dh hold registers A..D.
// - A host write to a time byte beats the hardware update.
// - Update once a second only when not inhibited and divider valid.
// - Update increments, checks overflow, checks alarm, writes back.
// - Update starts at least 488 ms after the busy flag, ends by 1984 ms.
// - Time bytes 0..9 read back FFh during the update; host writes still land.
// - One interrupt on vector 8 to both controllers, unshared, internal.
// - Two lockable 8-byte ranges, upper and lower lock bits.
// - Locked range ignores writes and reads back an undefined value.
// - A lock bit stays set until hard reset.
// - Well reset sets power-lost status and restores well defaults.
// - Standard and extended banks of 128 bytes; extended is plain RAM.
// - Extended bank uses index port 72h and data port 73h.
// - With upper bank disabled, 72h/76h and 73h/77h alias the standard ports.
// - Writes to 72h, 74h, 76h leave the NMI enable bit alone.
// - Reading the standard index port gives FFh; writes act normally.
module rtcr_top
    import rtcr_pkg::*;
#(
    parameter int UIP_LEAD_CYCLES = rtcr_pkg::UIP_LEAD_CYC,
    parameter int OSC_TICKS       = rtcr_pkg::OSC_HZ
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       osc_32k,
    input  wire logic       rtc_well_reset_n,
    input  wire logic [7:0] io_addr,
    input  wire logic       io_rd,
    input  wire logic       io_wr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       upper_bank_enable,
    input  wire logic       upper_range_lock_set,
    input  wire logic       lower_range_lock_set,
    input  wire logic       power_lost_clear,
    output logic      [7:0] io_rdata_q,
    output logic            nmi_enable_q,
    output logic            irq8_pic_q,
    output logic            irq8_apic_q,
    output logic            update_in_progress_q,
    output logic            power_lost_status_q,
    output logic            upper_range_lock_q,
    output logic            lower_range_lock_q
);
    import rtcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, divider and update sequencer
    logic        o1_q, o2_q, o3_q, osc_q, osc_d;
    logic        w1_q, w2_q, w3_q, wl_q, wl_d;
    logic [14:0] sub_q, sub_d, per_q, per_d, per_lim;
    logic [31:0] lead_q, lead_d;
    rtcr_state_e st_q, st_d;
    logic        uip_d, osc_rise, run, tick, per_tick;
    logic [6:0]  a_q, a_d;
    logic [7:0]  b_q, b_d;
    logic [5:0]  d_q, d_d;

    always_comb begin
        osc_d    = osc_q;
        wl_d     = wl_q;
        osc_rise = 1'b0;
        if (o2_q == o3_q) begin
            osc_d    = o2_q;
            osc_rise = o2_q & ~osc_q;
        end
        if (w2_q == w3_q) begin
            wl_d = ~w2_q;
        end
        run  = ~b_q[B_SET] & (a_q[6:4] == DIV_VALID) & ~wl_q;
        tick = 1'b0;
        sub_d = sub_q;
        if (!run) begin
            sub_d = '0;
        end else if (osc_rise) begin
            if (sub_q == 15'(OSC_TICKS - 1)) begin
                sub_d = '0;
                tick  = 1'b1;
            end else begin
                sub_d = sub_q + 15'h1;
            end
        end
        // Only the three slowest rates: 4096, 8192, 16384 oscillator edges
        per_lim  = 15'((32'h1 << (a_q[3:0] - 4'h1)) - 1);
        per_tick = 1'b0;
        per_d    = per_q;
        if (a_q[3:0] < PER_RATE_MIN || a_q[6:4] != DIV_VALID) begin
            per_d = '0;
        end else if (osc_rise) begin
            if (per_q >= per_lim) begin
                per_d    = '0;
                per_tick = 1'b1;
            end else begin
                per_d = per_q + 15'h1;
            end
        end
        st_d   = st_q;
        lead_d = lead_q;
        uip_d  = update_in_progress_q;
        unique case (st_q)
            ST_IDLE: begin
                if (tick) begin
                    st_d   = ST_LEAD;
                    lead_d = '0;
                    uip_d  = 1'b1;
                end
            end
            ST_LEAD: begin
                if (!run) begin
                    st_d  = ST_IDLE;
                    uip_d = 1'b0;
                end else if (lead_q == 32'(UIP_LEAD_CYCLES - 1)) begin
                    st_d = ST_UPD;
                end else begin
                    lead_d = lead_q + 32'h1;
                end
            end
            ST_UPD: begin
                st_d  = ST_IDLE;
                uip_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            o1_q <= 1'b0;
            o2_q <= 1'b0;
            o3_q <= 1'b0;
            osc_q <= 1'b0;
            w1_q <= 1'b1;
            w2_q <= 1'b1;
            w3_q <= 1'b1;
            wl_q <= 1'b0;
            sub_q <= '0;
            per_q <= '0;
            lead_q <= '0;
            st_q <= ST_IDLE;
            update_in_progress_q <= 1'b0;
        end else begin
            o1_q <= osc_32k;
            o2_q <= o1_q;
            o3_q <= o2_q;
            osc_q <= osc_d;
            w1_q <= rtc_well_reset_n;
            w2_q <= w1_q;
            w3_q <= w2_q;
            wl_q <= wl_d;
            sub_q <= sub_d;
            per_q <= per_d;
            lead_q <= lead_d;
            st_q <= st_d;
            update_in_progress_q <= uip_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time arithmetic
    function automatic logic [6:0] to_bin(input logic [7:0] v, input logic bin);
        return bin ? v[6:0] : 7'(v[7:4] * 10 + v[3:0]);
    endfunction : to_bin

    function automatic logic [7:0] to_fmt(input logic [6:0] v, input logic bin);
        return bin ? {1'b0, v} : {4'(v / 10), 4'(v % 10)};
    endfunction : to_fmt

    logic [7:0] tm_q [10];
    logic [7:0] tm_d [10];
    logic [7:0] nt [10];
    logic [6:0] sec, mnt, hr, h12, dow, dom, mon, yr, dim;
    logic [7:0] h12f;
    logic       bin, alarm_hit;

    always_comb begin
        bin = b_q[B_DM];
        sec = to_bin(tm_q[0], bin);
        mnt = to_bin(tm_q[2], bin);
        dow = to_bin(tm_q[6], bin);
        dom = to_bin(tm_q[7], bin);
        mon = to_bin(tm_q[8], bin);
        yr  = to_bin(tm_q[9], bin);
        if (b_q[B_24H]) begin
            hr = to_bin(tm_q[4], bin);
        end else begin
            hr = to_bin({1'b0, tm_q[4][6:0]}, bin);
            hr = ((hr == 7'd12) ? 7'd0 : hr) + (tm_q[4][7] ? 7'd12 : 7'd0);
        end
        unique case (mon)
            7'd2: dim = (yr[1:0] == 2'b00) ? 7'd29 : 7'd28;
            7'd4, 7'd6, 7'd9, 7'd11: dim = 7'd30;
            default: dim = 7'd31;
        endcase
        sec = sec + 7'd1;
        if (sec >= 7'd60) begin
            sec = '0;
            mnt = mnt + 7'd1;
            if (mnt >= 7'd60) begin
                mnt = '0;
                hr  = hr + 7'd1;
                if (hr >= 7'd24) begin
                    hr  = '0;
                    dow = (dow >= 7'd7) ? 7'd1 : dow + 7'd1;
                    dom = dom + 7'd1;
                    if (dom > dim) begin
                        dom = 7'd1;
                        mon = mon + 7'd1;
                        if (mon > 7'd12) begin
                            mon = 7'd1;
                            yr  = (yr >= 7'd99) ? 7'd0 : yr + 7'd1;
                        end
                    end
                end
            end
        end
        h12  = (hr % 7'd12 == 7'd0) ? 7'd12 : hr % 7'd12;
        h12f = to_fmt(h12, bin);
        nt    = tm_q;
        nt[0] = to_fmt(sec, bin);
        nt[2] = to_fmt(mnt, bin);
        nt[4] = b_q[B_24H] ? to_fmt(hr, bin) : {hr >= 7'd12, h12f[6:0]};
        nt[6] = to_fmt(dow, bin);
        nt[7] = to_fmt(dom, bin);
        nt[8] = to_fmt(mon, bin);
        nt[9] = to_fmt(yr, bin);
        // Top bits 11b in an alarm byte mean "any"; date 0 means any day
        alarm_hit = (tm_q[1][7:6] == 2'b11 || tm_q[1] == nt[0])
                  & (tm_q[3][7:6] == 2'b11 || tm_q[3] == nt[2])
                  & (tm_q[5][7:6] == 2'b11 || tm_q[5] == nt[4])
                  & (d_q == 6'h00 || d_q == 6'(dom));
    end

    ////////////////////////////////////////////////////////////////////////
    // Host ports, registers and flags
    logic [7:0] std_ram [128];
    logic [7:0] ext_ram [128];
    logic [6:0] sidx_q, sidx_d, xidx_q, xidx_d;
    logic [2:0] flg_q, flg_d;  // Periodic, alarm, update-ended
    logic [7:0] rdata_d;
    logic       nmi_d, pl_d, ul_d, ll_d, irq_d, hit, is_ext, is_idx;
    logic       std_we, ext_we, upd, rd_c, lo_lock, up_lock;

    always_comb begin
        hit    = io_addr[7:3] == PORT_BASE_HI;
        is_ext = io_addr[1] & upper_bank_enable;
        is_idx = ~io_addr[0];
        upd    = st_q == ST_UPD;
        lo_lock = lower_range_lock_q & (sidx_q[6:3] == LOCK_BASE[6:3]);
        up_lock = upper_range_lock_q & (xidx_q[6:3] == LOCK_BASE[6:3]);
        sidx_d = sidx_q;
        xidx_d = xidx_q;
        nmi_d  = nmi_enable_q;
        a_d    = a_q;
        b_d    = b_q;
        d_d    = d_q;
        tm_d   = upd ? nt : tm_q;
        std_we = 1'b0;
        ext_we = 1'b0;
        rd_c   = 1'b0;
        rdata_d = io_rdata_q;
        if (hit && io_wr) begin
            if (is_idx && is_ext) begin
                xidx_d = io_wdata[6:0];
            end else if (is_idx) begin
                sidx_d = io_wdata[6:0];
                if (io_addr[2:0] == 3'h0) begin
                    nmi_d = io_wdata[NMI_BIT];
                end
            end else if (is_ext) begin
                ext_we = ~up_lock;
            end else if (sidx_q <= IDX_TIME_LAST) begin
                tm_d[4'(sidx_q)] = io_wdata;
            end else if (sidx_q == IDX_REG_A) begin
                a_d = io_wdata[6:0];
            end else if (sidx_q == IDX_REG_B) begin
                b_d = io_wdata;
            end else if (sidx_q == IDX_REG_D) begin
                d_d = io_wdata[5:0];
            end else if (sidx_q > IDX_REG_D) begin
                std_we = ~lo_lock;
            end
        end
        if (hit && io_rd) begin
            if (is_idx) begin
                rdata_d = is_ext ? {1'b0, xidx_q} : READ_UNDEF;
            end else if (is_ext) begin
                rdata_d = up_lock ? READ_UNDEF : ext_ram[xidx_q];
            end else if (sidx_q <= IDX_TIME_LAST) begin
                rdata_d = upd ? READ_UNDEF : tm_q[4'(sidx_q)];
            end else if (sidx_q == IDX_REG_A) begin
                rdata_d = {update_in_progress_q, a_q};
            end else if (sidx_q == IDX_REG_B) begin
                rdata_d = b_q;
            end else if (sidx_q == IDX_REG_C) begin
                rdata_d = {irq8_pic_q, flg_q, 4'h0};
                rd_c    = 1'b1;
            end else if (sidx_q == IDX_REG_D) begin
                rdata_d = {1'b1, 1'b0, d_q};
            end else begin
                rdata_d = lo_lock ? READ_UNDEF : std_ram[sidx_q];
            end
        end
        // Reading C clears the flags, but a same-cycle event still lands
        flg_d = rd_c ? 3'h0 : flg_q;
        flg_d[2] = flg_d[2] | per_tick;
        flg_d[1] = flg_d[1] | (upd & alarm_hit);
        flg_d[0] = flg_d[0] | upd;
        irq_d = |(flg_d & {b_d[B_PIE], b_d[B_AIE], b_d[B_UIE]});
        ul_d  = upper_range_lock_q | upper_range_lock_set;
        ll_d  = lower_range_lock_q | lower_range_lock_set;
        pl_d  = power_lost_status_q & ~power_lost_clear;
        if (wl_q) begin
            pl_d = 1'b1;
            a_d  = REG_A_RST;
            b_d  = REG_B_RST;
            d_d  = REG_D_RST;
            irq_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sidx_q <= IDX_RST[6:0];
            xidx_q <= IDX_RST[6:0];
            nmi_enable_q <= IDX_RST[NMI_BIT];
            a_q <= REG_A_RST;
            b_q <= REG_B_RST;
            d_q <= REG_D_RST;
            tm_q <= '{default: DATA_RST};
            flg_q <= '0;
            io_rdata_q <= DATA_RST;
            irq8_pic_q <= 1'b0;
            irq8_apic_q <= 1'b0;
            power_lost_status_q <= 1'b0;
            upper_range_lock_q <= 1'b0;
            lower_range_lock_q <= 1'b0;
        end else begin
            sidx_q <= sidx_d;
            xidx_q <= xidx_d;
            nmi_enable_q <= nmi_d;
            a_q <= a_d;
            b_q <= b_d;
            d_q <= d_d;
            tm_q <= tm_d;
            flg_q <= flg_d;
            io_rdata_q <= rdata_d;
            irq8_pic_q <= irq_d;
            irq8_apic_q <= irq_d;
            power_lost_status_q <= pl_d;
            upper_range_lock_q <= ul_d;
            lower_range_lock_q <= ll_d;
        end
    end

    // Battery RAM keeps its contents; no reset on purpose
    always_ff @(posedge clk_sys) begin
        if (std_we) begin
            std_ram[sidx_q] <= io_wdata;
        end
        if (ext_we) begin
            ext_ram[xidx_q] <= io_wdata;
        end
    end

endmodule : rtcr_top

// File: shared/rtcr_pkg.sv
// Constants for the battery-backed clock with two banks of CMOS RAM.
// Assumes one 200 MHz system clock; ports are I/O port numbers, indices are RAM byte offsets.
package rtcr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // I/O ports and indices
    localparam logic [4:0] PORT_BASE_HI  = 5'h0E;   // Ports 70h..77h
    localparam logic [7:0] STD_INDEX_PORT = 8'h70;
    localparam logic [7:0] STD_DATA_PORT  = 8'h71;
    localparam logic [7:0] EXT_INDEX_PORT = 8'h72;
    localparam logic [7:0] EXT_DATA_PORT  = 8'h73;
    localparam logic [6:0] IDX_TIME_LAST  = 7'h09;
    localparam logic [6:0] IDX_REG_A      = 7'h0A;
    localparam logic [6:0] IDX_REG_B      = 7'h0B;
    localparam logic [6:0] IDX_REG_C      = 7'h0C;
    localparam logic [6:0] IDX_REG_D      = 7'h0D;
    localparam logic [6:0] LOCK_BASE      = 7'h38;  // 8-byte range 38h..3Fh
    localparam int         NMI_BIT        = 7;

    ////////////////////////////////////////////////////////////////////////
    // Register fields
    localparam int UPDATE_IN_PROGRESS = 7;
    localparam int B_SET = 7;
    localparam int B_PIE = 6;
    localparam int B_AIE = 5;
    localparam int B_UIE = 4;
    localparam int B_DM  = 2;
    localparam int B_24H = 1;
    localparam int C_IRQF = 7;
    localparam int D_VRT = 7;
    localparam logic [2:0] DIV_VALID    = 3'h2;
    localparam logic [3:0] PER_RATE_MIN = 4'hD;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [7:0] IDX_RST   = 8'h00;
    localparam logic [6:0] REG_A_RST = 7'h20;
    localparam logic [7:0] REG_B_RST = 8'h02;
    localparam logic [5:0] REG_D_RST = 6'h00;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [7:0] READ_UNDEF = 8'hFF;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int OSC_HZ        = 32768;           // Edges per second
    localparam int CLK_KHZ       = 200000;
    localparam int UIP_LEAD_MS   = 488;
    localparam int UPD_MAX_MS    = 1984;
    localparam int UIP_LEAD_CYC  = UIP_LEAD_MS * CLK_KHZ;

    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_UPD} rtcr_state_e;

endpackage : rtcr_pkg

// File: verif/rtcr_properties.sv
// Checker for rtcr_top, bound at the foot of this file.
// Sees the top ports only; counts come from the bound instance.
module rtcr_checker #(
    parameter int UIP_LEAD_CYCLES = 20,
    parameter int OSC_TICKS       = 8
) (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       osc_32k,
    input wire logic       rtc_well_reset_n,
    input wire logic [7:0] io_addr,
    input wire logic       io_rd,
    input wire logic       io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic       upper_bank_enable,
    input wire logic       upper_range_lock_set,
    input wire logic       lower_range_lock_set,
    input wire logic       power_lost_clear,
    input wire logic [7:0] io_rdata_q,
    input wire logic       nmi_enable_q,
    input wire logic       irq8_pic_q,
    input wire logic       irq8_apic_q,
    input wire logic       update_in_progress_q,
    input wire logic       power_lost_status_q,
    input wire logic       upper_range_lock_q,
    input wire logic       lower_range_lock_q
);
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // Busy span in cycles; a stuck flag shows as an overlong count
    always_comb begin
        busy_cnt_d = update_in_progress_q ? busy_cnt_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end
    sequence idx_rd_s;
        io_rd && (io_addr == 8'h70 || io_addr == 8'h74);
    endsequence
    sequence alias_rd_s;
        io_rd && !upper_bank_enable && (io_addr == 8'h72 || io_addr == 8'h76);
    endsequence
    sequence alias_wr_s;
        io_wr && (io_addr == 8'h72 || io_addr == 8'h74 || io_addr == 8'h76);
    endsequence
    // Sync takes 3 to 4 cycles, so 7 low samples leave margin
    sequence well_low_s;
        !rtc_well_reset_n [*7];
    endsequence
    index_read_ff_a: assert property (idx_rd_s |=> io_rdata_q == 8'hFF)
        else $error("index port read not FFh");
    alias_read_ff_a: assert property (alias_rd_s |=> io_rdata_q == 8'hFF)
        else $error("alias index read not FFh");
    nmi_write_a: assert property (io_wr && io_addr == 8'h70 |=> nmi_enable_q == $past(io_wdata[7]))
        else $error("nmi enable not taken from write");
    nmi_alias_a: assert property (alias_wr_s |=> $stable(nmi_enable_q))
        else $error("alias write moved nmi enable");
    locks_sticky_a: assert property (!$fell(upper_range_lock_q) && !$fell(lower_range_lock_q))
        else $error("lock bit cleared without reset");
    upper_lock_set_a: assert property (upper_range_lock_set |-> ##[1:2] upper_range_lock_q)
        else $error("upper lock not set");
    power_lost_a: assert property (well_low_s |-> power_lost_status_q)
        else $error("power lost status not set");
    well_irq_a: assert property (well_low_s |-> !irq8_pic_q)
        else $error("irq high during well reset");
    irq_pair_a: assert property (irq8_pic_q == irq8_apic_q)
        else $error("irq copies differ");
    busy_span_a: assert property ($fell(update_in_progress_q) |-> busy_cnt_q >= UIP_LEAD_CYCLES
        && busy_cnt_q <= UIP_LEAD_CYCLES + 2)
        else $error("busy flag span wrong");
endmodule : rtcr_checker

bind rtcr_top rtcr_checker #(
    .UIP_LEAD_CYCLES(UIP_LEAD_CYCLES),
    .OSC_TICKS      (OSC_TICKS)
) chk_u (
    .clk_sys(clk_sys), .rst(rst), .osc_32k(osc_32k),
    .rtc_well_reset_n(rtc_well_reset_n), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .upper_bank_enable(upper_bank_enable),
    .upper_range_lock_set(upper_range_lock_set), .lower_range_lock_set(lower_range_lock_set),
    .power_lost_clear(power_lost_clear), .io_rdata_q(io_rdata_q),
    .nmi_enable_q(nmi_enable_q), .irq8_pic_q(irq8_pic_q), .irq8_apic_q(irq8_apic_q),
    .update_in_progress_q(update_in_progress_q), .power_lost_status_q(power_lost_status_q),
    .upper_range_lock_q(upper_range_lock_q), .lower_range_lock_q(lower_range_lock_q)
);

// File: verif/rtcr_host.sv
// Host model: one-cycle port strobes, changed at falling edges.
// Assumes its tasks are called one at a time.
module rtcr_host (
    input  wire logic       clk_sys,
    input  wire logic [7:0] io_rdata_q,
    output logic      [7:0] io_addr,
    output logic            io_rd,
    output logic            io_wr,
    output logic      [7:0] io_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        io_addr  = 8'h00;
        io_rd    = 1'b0;
        io_wr    = 1'b0;
        io_wdata = 8'h00;
    end
    ////////////////////////////////////////
    // Released lines show the inverse, so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge clk_sys);
        io_wr    = 1'b0;
        io_addr  = ~a;
        io_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        io_addr = a;
        io_rd   = 1'b1;
        @(negedge clk_sys);
        io_rd   = 1'b0;
        io_addr = ~a;
        d       = io_rdata_q;
    endtask : rd
    // Index before data; top bit kept clear
    task automatic idx_wr(input logic [7:0] p, input logic [6:0] i);
        wr(p, {1'b0, i});
    endtask : idx_wr
endmodule : rtcr_host

// File: verif/rtcr_tb_top.sv
// Testbench for rtcr_top: host model on the port bus, pins driven here.
// Short counts: 20 lead cycles, 8 oscillator edges a second.
module rtcr_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import rtcr_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       osc_32k = 1'b0;
    logic       rtc_well_reset_n = 1'b1;
    logic       upper_bank_enable = 1'b1;
    logic       upper_range_lock_set = 1'b0;
    logic       lower_range_lock_set = 1'b0;
    logic       power_lost_clear = 1'b0;
    logic [7:0] io_addr, io_wdata, io_rdata_q;
    logic       io_rd, io_wr, nmi_enable_q, irq8_pic_q, irq8_apic_q;
    logic       update_in_progress_q, power_lost_status_q;
    logic       upper_range_lock_q, lower_range_lock_q;
    int         errors = 0;
    int         checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    always #50 osc_32k = ~osc_32k;
    rtcr_top #(.UIP_LEAD_CYCLES(20), .OSC_TICKS(8)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .osc_32k(osc_32k),
        .rtc_well_reset_n(rtc_well_reset_n), .io_addr(io_addr), .io_rd(io_rd),
        .io_wr(io_wr), .io_wdata(io_wdata), .upper_bank_enable(upper_bank_enable),
        .upper_range_lock_set(upper_range_lock_set), .lower_range_lock_set(lower_range_lock_set),
        .power_lost_clear(power_lost_clear), .io_rdata_q(io_rdata_q),
        .nmi_enable_q(nmi_enable_q), .irq8_pic_q(irq8_pic_q), .irq8_apic_q(irq8_apic_q),
        .update_in_progress_q(update_in_progress_q), .power_lost_status_q(power_lost_status_q),
        .upper_range_lock_q(upper_range_lock_q), .lower_range_lock_q(lower_range_lock_q));
    rtcr_host host_u (.clk_sys(clk_sys), .io_rdata_q(io_rdata_q), .io_addr(io_addr),
        .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata));
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic chb(input logic g, input logic e);
        chk({7'h00, g}, {7'h00, e});
    endtask : chb
    task automatic put(input logic [7:0] p, input logic [6:0] i, input logic [7:0] d);
        host_u.idx_wr(p, i);
        host_u.wr(p + 8'h01, d);
    endtask : put
    task automatic get(input logic [7:0] p, input logic [6:0] i, output logic [7:0] v);
        host_u.idx_wr(p, i);
        host_u.rd(p + 8'h01, v);
    endtask : get
    task automatic pulse(ref logic s);
        @(negedge clk_sys);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask : pulse
    task automatic do_reset;
        @(negedge clk_sys);
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
    endtask : do_reset
    // Bounded wait for one whole update; irq and flags rise on the edge that drops the busy flag
    task automatic wait_upd;
        int n;
        n = 0;
        while (update_in_progress_q !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        chb(update_in_progress_q, 1'b1);
        while (update_in_progress_q !== 1'b0 && n < 800) begin
            @(negedge clk_sys);
            n++;
        end
        chb(update_in_progress_q, 1'b0);
        @(negedge clk_sys);
    endtask : wait_upd
    task automatic t_banks;
        logic [7:0] v;
        host_u.rd(8'h71, v);
        chk(v, DATA_RST);
        get(8'h70, IDX_REG_A, v);
        chk(v, 8'h20);
        get(8'h70, IDX_REG_B, v);
        chk(v, REG_B_RST);
        host_u.rd(8'h72, v);
        chk(v, 8'h00);
        host_u.rd(8'h74, v);
        chk(v, READ_UNDEF);
        put(8'h70, 7'h20, 8'h5A);
        put(8'h72, 7'h20, 8'hA5);
        get(8'h74, 7'h20, v);
        chk(v, 8'h5A);
        get(8'h76, 7'h20, v);
        chk(v, 8'hA5);
        $display("test banks done");
    endtask : t_banks
    task automatic t_alias;
        logic [7:0] v;
        upper_bank_enable = 1'b0;
        host_u.wr(8'h70, 8'h80);
        chb(nmi_enable_q, 1'b1);
        put(8'h76, 7'h21, 8'h3C);
        host_u.wr(8'h74, 8'h00);
        host_u.wr(8'h72, 8'h21);
        chb(nmi_enable_q, 1'b1);
        host_u.rd(8'h73, v);
        chk(v, 8'h3C);
        host_u.rd(8'h76, v);
        chk(v, READ_UNDEF);
        host_u.wr(8'h70, 8'h21);
        chb(nmi_enable_q, 1'b0);
        upper_bank_enable = 1'b1;
        get(8'h72, 7'h20, v);
        chk(v, 8'hA5);
        $display("test alias done");
    endtask : t_alias
    task automatic t_lock;
        logic [7:0] v;
        put(8'h70, LOCK_BASE, 8'h11);
        put(8'h72, LOCK_BASE + 7'h07, 8'h22);
        pulse(lower_range_lock_set);
        get(8'h70, LOCK_BASE, v);
        chk(v, READ_UNDEF);
        put(8'h70, LOCK_BASE, 8'h33);
        get(8'h72, LOCK_BASE + 7'h07, v);
        chk(v, 8'h22);
        pulse(upper_range_lock_set);
        get(8'h72, LOCK_BASE + 7'h07, v);
        chk(v, READ_UNDEF);
        chk({6'h00, upper_range_lock_q, lower_range_lock_q}, 8'h03);
        do_reset();
        chk({6'h00, upper_range_lock_q, lower_range_lock_q}, 8'h00);
        get(8'h70, LOCK_BASE, v);
        chk(v, 8'h11);
        $display("test lock done");
    endtask : t_lock
    task automatic t_update;
        logic [7:0] v;
        logic [7:0] w;
        wait_upd();
        put(8'h70, IDX_REG_B, 8'h12);
        put(8'h70, 7'h00, 8'h59);
        put(8'h70, 7'h02, 8'h00);
        wait_upd();
        get(8'h70, 7'h00, v);
        chk(v, 8'h00);
        get(8'h70, 7'h02, v);
        chk(v, 8'h01);
        chb(irq8_pic_q, 1'b1);
        get(8'h70, IDX_REG_C, v);
        chk(v, 8'h90);
        chb(irq8_apic_q, 1'b0);
        put(8'h70, 7'h01, 8'hC0);
        put(8'h70, 7'h03, 8'hC0);
        put(8'h70, 7'h05, 8'hC0);
        put(8'h70, IDX_REG_B, 8'h22);
        wait_upd();
        chb(irq8_apic_q, 1'b1);
        get(8'h70, IDX_REG_C, v);
        chk(v, 8'hB0);
        put(8'h70, IDX_REG_B, 8'h82);
        get(8'h70, 7'h00, w);
        repeat (400) @(negedge clk_sys);
        get(8'h70, 7'h00, v);
        chk(v, w);
        $display("test update done");
    endtask : t_update
    task automatic t_well;
        logic [7:0] v;
        @(negedge clk_sys);
        rtc_well_reset_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        chb(power_lost_status_q, 1'b1);
        rtc_well_reset_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        get(8'h70, IDX_REG_B, v);
        chk(v, REG_B_RST);
        pulse(power_lost_clear);
        chb(power_lost_status_q, 1'b0);
        $display("test well done");
    endtask : t_well
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    initial begin
        do_reset();
        t_banks();
        t_alias();
        t_lock();
        t_update();
        t_well();
        print_verdict();
    end
    // About 1000 cycles expected; ten times that means a hang
    initial begin
        #50000;
        errors++;
        print_verdict();
    end
endmodule : rtcr_tb_top
